// ==== core/agc_pkg.sv ====
// Function
// [RULE1] gain code 0 mutes, 1 is 0 dB, each step adds 0.5 dB to 31 dB
// [RULE2] right third-set bit 7 is a test bit reading 1; never write it
// [RULE3] third-set enable 1: startup gains come from the third set only
// [RULE4] third-set enable 0: third-set gains are inactive at startup
// [RULE5] software programs the third set after primary and second sets
// [RULE6] source select 00 preamp, 01 op-amp one, 11 nothing but line input
// [RULE7] software never writes source select code 10
// [RULE8] line mute 1 disconnects line input from headphone amplifier
// [RULE9] path bit 1 switches op-amp one right channel in noise-cancel mode
// [RULE10] path bit 0 switches op-amp one left channel in noise-cancel mode
// [RULE11] second-set enable 0 makes the second set inactive at startup
// [RULE12] monitor mode uses its own source select; this one is noise-cancel only
// [RULE13] startup applies third set, else second set, else primary set
package agc_pkg;
  localparam logic [7:0] AGC_OFS_R3 = 8'h12;
  localparam logic [7:0] AGC_OFS_L3 = 8'h13;
  localparam logic [7:0] AGC_OFS_PATH = 8'h14;
  localparam logic [7:0] AGC_OFS_STATUS = 8'h18;
  localparam logic [7:0] AGC_RST_R3 = 8'h80;
  localparam logic [7:0] AGC_RST_L3 = 8'h00;
  localparam logic [7:0] AGC_RST_PATH = 8'h00;
  localparam int AGC_TEST_BIT = 7;
  localparam int AGC_ENA_BIT = 7;
  localparam int AGC_MUX_HI = 7;
  localparam int AGC_MUX_LO = 6;
  localparam int AGC_MUTE_BIT = 4;
  localparam int AGC_OP1R_BIT = 1;
  localparam int AGC_OP1L_BIT = 0;
  localparam logic [5:0] AGC_GAIN_MUTE = 6'h00;
  localparam logic [1:0] AGC_SRC_PREAMP = 2'h0;
  localparam logic [1:0] AGC_SRC_OPAMP = 2'h1;
  localparam logic [1:0] AGC_SRC_BAD = 2'h2;
  localparam logic [1:0] AGC_SRC_NONE = 2'h3;
  localparam logic [1:0] AGC_SET_PRIMARY = 2'h0;
  localparam logic [1:0] AGC_SET_SECOND = 2'h1;
  localparam logic [1:0] AGC_SET_THIRD = 2'h2;
endpackage : agc_pkg

// ==== core/agc_regs.sv ====
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
module agc_regs
  import agc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic startup_req,
  input wire logic nc_mode,
  input wire logic [5:0] right_mic_gain_primary,
  input wire logic [5:0] left_mic_gain_primary,
  input wire logic [5:0] right_mic_gain_second_set,
  input wire logic [5:0] left_mic_gain_second_set,
  input wire logic second_set_enable,
  input wire logic [1:0] monitor_headphone_source_select,
  input wire logic line_in_present,
  output logic [5:0] right_gain_applied,
  output logic [5:0] left_gain_applied,
  output logic right_mute,
  output logic left_mute,
  output logic [1:0] headphone_source_select,
  output logic line_to_headphone,
  output logic right_opamp_one_enable,
  output logic left_opamp_one_enable
);
  import agc_pkg::*;

  logic [6:0] right_gain_code_third;
  logic [6:0] left_gain_code_third;
  logic [7:0] noise_cancel_path_config;
  logic [6:0] next_right_gain_code_third;
  logic [6:0] next_left_gain_code_third;
  logic [7:0] next_noise_cancel_path_config;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic [5:0] next_right_gain_applied;
  logic [5:0] next_left_gain_applied;
  logic [1:0] active_set;
  logic [1:0] next_active_set;
  logic [1:0] hp_src;
  logic line_on;
  logic op_r;
  logic op_l;
  logic sp_meta;
  logic sp_sync;
  logic sp_prev;
  logic nc_meta;
  logic nc_sync;
  logic sync_en_meta;
  logic sync_en;

  // register read mux; unmapped offsets read zero
  function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [6:0] r3,
                                        input logic [6:0] l3, input logic [7:0] p,
                                        input logic [1:0] s);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      AGC_OFS_R3: v = {1'b1, 1'b0, r3[5:0]}; // RULE2
      AGC_OFS_L3: v = {l3[6], 1'b0, l3[5:0]};
      AGC_OFS_PATH: v = {p[7:6], 1'b0, p[4], 2'h0, p[1:0]};
      AGC_OFS_STATUS: v = {6'h00, s};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_reg

  // one wait cycle per access: waitrequest drops on the cycle after the request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  // bus write and read data; gain bit 6 keeps no storage, path bits 5 and 3:2 read zero
  always_comb begin
    next_right_gain_code_third = right_gain_code_third;
    next_left_gain_code_third = left_gain_code_third;
    next_noise_cancel_path_config = noise_cancel_path_config;
    next_ack = (avs_read | avs_write) & ~ack;
    next_readdata = avs_readdata;
    // commit on the edge where the master sees waitrequest low, not before
    if (avs_write && ack && avs_byteenable[0]) begin
      unique case (avs_address)
        // test bit is not stored, so a stray write cannot clear it
        AGC_OFS_R3: next_right_gain_code_third = {1'b0, avs_writedata[5:0]}; // RULE2
        AGC_OFS_L3: next_left_gain_code_third = {avs_writedata[7], avs_writedata[5:0]};
        AGC_OFS_PATH: next_noise_cancel_path_config = avs_writedata[7:0];
        default: ;
      endcase
    end
    if (avs_read && !ack) begin
      next_readdata = {24'h000000, rd_reg(avs_address, right_gain_code_third,
                       left_gain_code_third, noise_cancel_path_config, active_set)};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      right_gain_code_third <= {1'b0, AGC_RST_R3[5:0]};
      left_gain_code_third <= {AGC_RST_L3[7], AGC_RST_L3[5:0]};
      noise_cancel_path_config <= AGC_RST_PATH;
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      right_gain_code_third <= next_right_gain_code_third;
      left_gain_code_third <= next_left_gain_code_third;
      noise_cancel_path_config <= next_noise_cancel_path_config;
      ack <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  // startup, noise-cancel and second-set enable pins pass two flops before use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sp_meta <= 1'b0;
      sp_sync <= 1'b0;
      sp_prev <= 1'b0;
      nc_meta <= 1'b0;
      nc_sync <= 1'b0;
      sync_en_meta <= 1'b0;
      sync_en <= 1'b0;
    end else begin
      sp_meta <= startup_req;
      sp_sync <= sp_meta;
      sp_prev <= sp_sync;
      nc_meta <= nc_mode;
      nc_sync <= nc_meta;
      sync_en_meta <= second_set_enable;
      sync_en <= sync_en_meta;
    end
  end

  // gain set chosen once at startup edge; later writes wait for next startup
  always_comb begin
    next_right_gain_applied = right_gain_applied;
    next_left_gain_applied = left_gain_applied;
    next_active_set = active_set;
    if (sp_sync && !sp_prev) begin
      if (left_gain_code_third[6]) begin // RULE3 RULE13
        next_right_gain_applied = right_gain_code_third[5:0];
        next_left_gain_applied = left_gain_code_third[5:0];
        next_active_set = AGC_SET_THIRD;
      end else if (sync_en) begin // RULE4 RULE11 RULE13
        next_right_gain_applied = right_mic_gain_second_set;
        next_left_gain_applied = left_mic_gain_second_set;
        next_active_set = AGC_SET_SECOND;
      end else begin // RULE13
        next_right_gain_applied = right_mic_gain_primary;
        next_left_gain_applied = left_mic_gain_primary;
        next_active_set = AGC_SET_PRIMARY;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      right_gain_applied <= AGC_GAIN_MUTE;
      left_gain_applied <= AGC_GAIN_MUTE;
      active_set <= AGC_SET_PRIMARY;
    end else begin
      right_gain_applied <= next_right_gain_applied;
      left_gain_applied <= next_left_gain_applied;
      active_set <= next_active_set;
    end
  end

  // path control; monitor select takes over outside noise-cancel mode
  always_comb begin
    hp_src = nc_sync ? noise_cancel_path_config[AGC_MUX_HI:AGC_MUX_LO] // RULE6
                     : monitor_headphone_source_select; // RULE12
    // forbidden code falls back to no source as the safe choice
    if (hp_src == AGC_SRC_BAD) hp_src = AGC_SRC_NONE;
    line_on = line_in_present & ~noise_cancel_path_config[AGC_MUTE_BIT]; // RULE8
    op_r = nc_sync & noise_cancel_path_config[AGC_OP1R_BIT]; // RULE9
    op_l = nc_sync & noise_cancel_path_config[AGC_OP1L_BIT]; // RULE10
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      headphone_source_select <= AGC_SRC_PREAMP;
      line_to_headphone <= 1'b0;
      right_opamp_one_enable <= 1'b0;
      left_opamp_one_enable <= 1'b0;
      right_mute <= 1'b1;
      left_mute <= 1'b1;
    end else begin
      headphone_source_select <= hp_src;
      line_to_headphone <= line_on;
      right_opamp_one_enable <= op_r;
      left_opamp_one_enable <= op_l;
      right_mute <= (next_right_gain_applied == AGC_GAIN_MUTE); // RULE1
      left_mute <= (next_left_gain_applied == AGC_GAIN_MUTE); // RULE1
    end
  end
endmodule : agc_regs

// ==== tb/agc_regs_chk.sv ====
`timescale 1ns/100ps
module agc_regs_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic startup_req,
  input wire logic nc_mode,
  input wire logic line_in_present,
  input wire logic [5:0] right_gain_applied,
  input wire logic [5:0] left_gain_applied,
  input wire logic right_mute,
  input wire logic left_mute,
  input wire logic [1:0] headphone_source_select,
  input wire logic line_to_headphone,
  input wire logic right_opamp_one_enable,
  input wire logic left_opamp_one_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // slave answers after exactly one wait cycle
  AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  AST_RMUTE: assert property (right_mute == (right_gain_applied == 6'h00))
    else $error("right mute wrong");
  AST_LMUTE: assert property (left_mute == (left_gain_applied == 6'h00))
    else $error("left mute wrong");
  AST_TEST: assert property (avs_read && !avs_waitrequest && avs_address == 8'h12 |-> avs_readdata[7])
    else $error("test bit read low");
  AST_SRC: assert property (headphone_source_select != 2'h2)
    else $error("forbidden source driven");
  // gains move only after a startup edge, so a quiet pin freezes them
  AST_STABLE: assert property (!startup_req [*4] |=> $stable(right_gain_applied) && $stable(left_gain_applied))
    else $error("gain changed without startup");
  AST_OPAMP: assert property (!nc_mode [*4] |=> !right_opamp_one_enable && !left_opamp_one_enable)
    else $error("op-amp on outside noise-cancel");
  AST_LINE: assert property (!line_in_present [*4] |=> !line_to_headphone)
    else $error("line path without line input");
  // main scenarios reached
  cover property (avs_write && !avs_waitrequest && avs_address == 8'h14);
  cover property ($rose(startup_req));
  cover property (nc_mode && right_opamp_one_enable);
endmodule : agc_regs_chk
bind agc_regs agc_regs_chk agc_regs_chk_inst (.*);

// ==== tb/agc_regs_tb_top.sv ====
`timescale 1ns/100ps
module agc_regs_tb_top;
  logic mclk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, startup_req = 1'b0;
  logic nc_mode = 1'b0, second_set_enable = 1'b0, line_in_present = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'h1;
  logic [5:0] right_mic_gain_primary = 6'h05, left_mic_gain_primary = 6'h06;
  logic [5:0] right_mic_gain_second_set = 6'h07, left_mic_gain_second_set = 6'h08;
  logic [5:0] right_gain_applied, left_gain_applied;
  logic [1:0] monitor_headphone_source_select = 2'h1, headphone_source_select;
  logic avs_waitrequest, right_mute, left_mute, line_to_headphone;
  logic right_opamp_one_enable, left_opamp_one_enable;
  logic [7:0] paths [3] = '{8'h02, 8'h41, 8'hd3};
  int errors = 0, samples_checked = 0;
  agc_regs agc_regs_inst (.*);
  always #20 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one access; a read compares its data with d
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    if (!wr) chk(avs_readdata, {24'h0, d});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // quiet gap first so the synchroniser sees a clean rise
  task automatic boot(input logic [5:0] r, input logic [5:0] l);
    repeat (4) @(posedge mclk);
    startup_req <= 1'b1;
    repeat (8) @(posedge mclk);
    startup_req <= 1'b0;
    chk({right_mute, right_gain_applied}, {r == 6'h00, r});
    chk(left_gain_applied, l);
  endtask : boot
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    bus(0, 8'h12, 8'h80);
    bus(0, 8'h13, 8'h00);
    bus(0, 8'h14, 8'h00);
    bus(0, 8'h20, 8'h00);
    bus(1, 8'h12, 8'h3f);
    bus(0, 8'h12, 8'hbf);
    $display("test registers done");
    // lane 0 off drops the write, so the third set stays off
    avs_byteenable <= 4'h0;
    bus(1, 8'h13, 8'h80);
    avs_byteenable <= 4'h1;
    bus(0, 8'h13, 8'h00);
    boot(6'h05, 6'h06);
    second_set_enable <= 1'b1;
    boot(6'h07, 6'h08);
    bus(1, 8'h12, 8'h80);
    bus(1, 8'h13, 8'hbf);
    boot(6'h00, 6'h3f);
    $display("test startup done");
    nc_mode <= 1'b1;
    foreach (paths[i]) begin
      bus(1, 8'h14, paths[i]);
      bus(0, 8'h14, paths[i]);
      repeat (4) @(posedge mclk);
      chk(headphone_source_select, paths[i][7:6]);
      chk(line_to_headphone, !paths[i][4]);
      chk({right_opamp_one_enable, left_opamp_one_enable}, paths[i][1:0]);
    end
    // monitor mode uses its own select and drops the op-amps
    nc_mode <= 1'b0;
    line_in_present <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(headphone_source_select, monitor_headphone_source_select);
    chk({right_opamp_one_enable, left_opamp_one_enable}, 2'h0);
    chk(line_to_headphone, 1'b0);
    // forbidden select code must never reach the amplifier mux
    monitor_headphone_source_select <= 2'h2;
    repeat (6) @(posedge mclk);
    chk(headphone_source_select, 2'h3);
    $display("test path done");
    conclude();
  end
  // run needs about 115 cycles; this limit of 2500 cycles is far beyond
  initial begin
    #100000;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : agc_regs_tb_top
